// *** tgc_pkg.sv ***
// package: register map, field layout, reset values and types for the timer gate control block
package tgc_pkg;

  // register byte addresses on the apb bus
  localparam logic [7:0] TGC_OFS_CNT_LOW = 8'h00;
  localparam logic [7:0] TGC_OFS_CNT_HIGH = 8'h04;
  localparam logic [7:0] TGC_OFS_TCTRL = 8'h08;
  localparam logic [7:0] TGC_OFS_GCTRL = 8'h0c;
  localparam logic [7:0] TGC_OFS_FLAG = 8'h10;
  localparam logic [7:0] TGC_OFS_IEN = 8'h14;

  // timer_control fields
  localparam int TGC_TC_CS_HI = 7;
  localparam int TGC_TC_CS_LO = 6;
  localparam int TGC_TC_PS_HI = 5;
  localparam int TGC_TC_PS_LO = 4;
  localparam int TGC_TC_OSCEN = 3;
  localparam int TGC_TC_SYNC = 2;
  localparam int TGC_TC_CMPSYNC = 1;
  localparam int TGC_TC_ON = 0;

  // gate_control fields
  localparam int TGC_GC_GE = 7;
  localparam int TGC_GC_POL = 6;
  localparam int TGC_GC_TM = 5;
  localparam int TGC_GC_SPM = 4;
  localparam int TGC_GC_GO = 3;
  localparam int TGC_GC_VAL = 2;
  localparam int TGC_GC_SS_HI = 1;
  localparam int TGC_GC_SS_LO = 0;

  // flag and enable registers use bit 0
  localparam int TGC_FLAG_BIT = 0;

  // values after reset
  localparam logic [7:0] TGC_RST_TCTRL = 8'h00;
  localparam logic [7:0] TGC_RST_GCTRL = 8'h00;
  localparam logic [15:0] TGC_RST_COUNT = 16'h0000;

  // eight-bit timer wrap points
  localparam logic [7:0] TGC_T0_TOP = 8'hff;
  localparam logic [7:0] TGC_T0_ZERO = 8'h00;

  typedef enum logic [1:0] {
    TGC_SRC_PIN = 2'b00,
    TGC_SRC_T0OVF = 2'b01,
    TGC_SRC_CMP = 2'b10,
    TGC_SRC_RSVD = 2'b11
  } tgc_src_t;

  // single-pulse sequencer, one-hot
  typedef enum logic [2:0] {
    TGC_SP_IDLE = 3'b001,
    TGC_SP_ARM = 3'b010,
    TGC_SP_RUN = 3'b100
  } tgc_sp_t;

  typedef struct packed {
    logic ge;
    logic pol;
    logic tm;
    logic spm;
    tgc_src_t gss;
    logic cmp_sync;
  } tgc_gcfg_t;

  // one apb access as seen by the register file
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
  } tgc_wreq_t;

endpackage

// *** tgc_apb_slv.sv ***
// apb slave front end: one wait state, registered read data and error answer
`timescale 1ns/1ps
module tgc_apb_slv
  import tgc_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // register file side
  input wire logic [7:0] i_rdata,
  input wire logic i_hit,
  output tgc_wreq_t o_wreq
);

  logic pready_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  // the cycle before pready rises is when read data and decode are captured
  wire access_w = i_psel & i_penable & ~pready_r;
  // the write lands on the same edge the master samples pready high
  wire commit_w = i_psel & i_penable & pready_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= access_w;
      if (access_w) begin
        prdata_r <= (i_pwrite || !i_hit) ? 32'h0000_0000 : {24'h00_0000, i_rdata};
        pslverr_r <= ~i_hit;
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  assign o_wreq.wr = commit_w & i_pwrite & i_hit;
  assign o_wreq.addr = i_paddr;
  assign o_wreq.data = i_pwdata[7:0];
  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;

endmodule

// *** tgc_top.sv ***
// timer with selectable, polarity, toggle and single-pulse gate control behind apb
`timescale 1ns/1ps
module tgc_top
  import tgc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // gate and clock sources
  input wire logic i_gate_pin,
  input wire logic [7:0] i_t0_count,
  input wire logic i_cmp_out,
  input wire logic i_tclk_pin,
  // status
  output logic o_gate_value,
  output logic o_gate_irq,
  output logic [CNT_W-1:0] o_count
);

  // register storage
  logic [7:0] tctrl_r;
  logic [7:0] gctrl_r;
  logic go_r;
  logic go_nxt;
  logic flag_r;
  logic flag_nxt;
  logic ien_r;
  logic ien_nxt;
  logic irq_r;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic [2:0] ps_r;
  logic [2:0] ps_nxt;

  // gate path state
  logic tclk_prev_r;
  logic [7:0] t0_prev_r;
  logic t0_pulse_r;
  logic cmp_s_r;
  logic act_prev_r;
  logic tff_r;
  logic tg_prev_r;
  logic gval_r;
  logic gval_nxt;
  tgc_sp_t sp_r;
  tgc_sp_t sp_nxt;

  tgc_wreq_t wreq;
  tgc_gcfg_t cfg;
  logic [7:0] rdata;
  logic hit;

  // one address compare shared by the write strobes and the read mux
  function automatic logic reg_at(
    input logic [7:0] addr,
    input logic [7:0] ofs
  );
    return addr == ofs;
  endfunction

  tgc_apb_slv u_apb (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_pwrite(i_pwrite),
    .i_paddr(i_paddr),
    .i_pwdata(i_pwdata),
    .o_prdata(o_prdata),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .i_rdata(rdata),
    .i_hit(hit),
    .o_wreq(wreq)
  );

  // ---------------- address decode ----------------
  wire wr_low = wreq.wr && reg_at(wreq.addr, TGC_OFS_CNT_LOW);
  wire wr_high = wreq.wr && reg_at(wreq.addr, TGC_OFS_CNT_HIGH);
  wire wr_tc = wreq.wr && reg_at(wreq.addr, TGC_OFS_TCTRL);
  wire wr_gc = wreq.wr && reg_at(wreq.addr, TGC_OFS_GCTRL);
  wire wr_flag = wreq.wr && reg_at(wreq.addr, TGC_OFS_FLAG);
  wire wr_ien = wreq.wr && reg_at(wreq.addr, TGC_OFS_IEN);

  always_comb begin
    hit = 1'b1;
    if (reg_at(i_paddr, TGC_OFS_CNT_LOW)) begin
      rdata = count_r[7:0];
    end else if (reg_at(i_paddr, TGC_OFS_CNT_HIGH)) begin
      rdata = count_r[15:8];
    end else if (reg_at(i_paddr, TGC_OFS_TCTRL)) begin
      rdata = tctrl_r;
    end else if (reg_at(i_paddr, TGC_OFS_GCTRL)) begin
      // live go/done and gate value are merged into the stored fields
      rdata = {gctrl_r[7:4], go_r, gval_r, gctrl_r[1:0]};
    end else if (reg_at(i_paddr, TGC_OFS_FLAG)) begin
      rdata = {7'h00, flag_r};
    end else if (reg_at(i_paddr, TGC_OFS_IEN)) begin
      rdata = {7'h00, ien_r};
    end else begin
      rdata = 8'h00;
      hit = 1'b0;
    end
  end

  assign cfg.ge = gctrl_r[TGC_GC_GE];
  assign cfg.pol = gctrl_r[TGC_GC_POL];
  assign cfg.tm = gctrl_r[TGC_GC_TM];
  assign cfg.spm = gctrl_r[TGC_GC_SPM];
  assign cfg.gss = tgc_src_t'(gctrl_r[TGC_GC_SS_HI:TGC_GC_SS_LO]);
  assign cfg.cmp_sync = tctrl_r[TGC_TC_CMPSYNC];

  // ---------------- timer clock and prescaler ----------------
  wire ext_clk = tctrl_r[TGC_TC_CS_HI];
  wire timer_on = tctrl_r[TGC_TC_ON];
  wire [1:0] ps_sel = tctrl_r[TGC_TC_PS_HI:TGC_TC_PS_LO];
  // rising edge of the timer clock source; internal source ticks every cycle
  wire tclk_tick = ext_clk ? (i_tclk_pin & ~tclk_prev_r) : 1'b1;
  // prescaler advances on source ticks only, so a slow pin divides further
  wire [2:0] ps_mask = 3'((4'h1 << ps_sel) - 4'h1);
  wire ps_done = tclk_tick && ((ps_r & ps_mask) == ps_mask);

  // ---------------- gate source and polarity ----------------
  // raw path follows the comparator at once; the synced path trades a tick of delay for a clean edge
  wire cmp_lvl = cfg.cmp_sync ? cmp_s_r : i_cmp_out;
  logic src_lvl;
  always_comb begin
    case (cfg.gss)
      TGC_SRC_PIN: src_lvl = i_gate_pin;
      TGC_SRC_T0OVF: src_lvl = t0_pulse_r;
      TGC_SRC_CMP: src_lvl = cmp_lvl;
      default: src_lvl = 1'b0;
    endcase
  end

  // high when the source sits at the level that lets the timer count
  wire act_lvl = ~(src_lvl ^ cfg.pol);
  wire act_rise = act_lvl & ~act_prev_r;
  // toggle flop output stands in for the gate when toggle mode is on
  wire tg = cfg.tm ? tff_r : act_lvl;
  wire tg_rise = tg & ~tg_prev_r;
  wire tg_fall = ~tg & tg_prev_r;

  // ---------------- single-pulse sequencer ----------------
  always_comb begin
    sp_nxt = sp_r;
    go_nxt = go_r;
    if (wr_gc) begin
      go_nxt = wreq.data[TGC_GC_GO];
    end
    // arm waits for a fresh rising edge so a gate already high is not measured
    case (sp_r)
      TGC_SP_IDLE: begin
        if (cfg.spm && go_r) begin
          sp_nxt = TGC_SP_ARM;
        end
      end
      TGC_SP_ARM: begin
        if (!cfg.spm || !go_r) begin
          sp_nxt = TGC_SP_IDLE;
        end else if (tg_rise) begin
          sp_nxt = TGC_SP_RUN;
        end
      end
      TGC_SP_RUN: begin
        if (!cfg.spm || !go_r) begin
          sp_nxt = TGC_SP_IDLE;
        end else if (tg_fall) begin
          // trailing edge ends the capture; hardware clear beats a same-cycle write
          sp_nxt = TGC_SP_IDLE;
          go_nxt = 1'b0;
        end
      end
      default: sp_nxt = TGC_SP_IDLE;
    endcase
  end

  // gate value follows the sequencer in single-pulse mode, so later edges stay blocked
  assign gval_nxt = cfg.spm ? (sp_nxt == TGC_SP_RUN) : tg;

  // falling gate value raises the event flag regardless of gate enable; set beats clear
  wire gate_evt = gval_r & ~gval_nxt;
  wire flag_clr = wr_flag & ~wreq.data[TGC_FLAG_BIT];
  assign flag_nxt = gate_evt | (flag_r & ~flag_clr);
  // enable and flag reach the irq output on the same edge
  assign ien_nxt = wr_ien ? wreq.data[TGC_FLAG_BIT] : ien_r;

  // ---------------- counter ----------------
  // gating only matters with the gate enable bit set
  wire gate_ok = ~cfg.ge | gval_r;
  wire inc = timer_on & ps_done & gate_ok;

  always_comb begin
    count_nxt = count_r;
    ps_nxt = ps_r;
    if (wr_low || wr_high) begin
      ps_nxt = 3'h0;
    end else if (tclk_tick && timer_on) begin
      ps_nxt = ps_done ? 3'h0 : 3'(ps_r + 3'h1);
    end
    // a byte write wins over an increment in the same cycle
    if (wr_low) begin
      count_nxt[7:0] = wreq.data;
    end else if (wr_high) begin
      count_nxt[15:8] = wreq.data;
    end else if (inc) begin
      count_nxt = count_r + 1'b1;
    end
  end

  // ---------------- registers ----------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tctrl_r <= TGC_RST_TCTRL;
      gctrl_r <= TGC_RST_GCTRL;
      ien_r <= 1'b0;
    end else begin
      if (wr_tc) begin
        tctrl_r <= wreq.data;
      end
      if (wr_gc) begin
        gctrl_r <= wreq.data;
      end
      if (wr_ien) begin
        ien_r <= wreq.data[TGC_FLAG_BIT];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_r <= TGC_RST_COUNT;
      ps_r <= 3'h0;
      go_r <= 1'b0;
      sp_r <= TGC_SP_IDLE;
      flag_r <= 1'b0;
      irq_r <= 1'b0;
      gval_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      ps_r <= ps_nxt;
      go_r <= go_nxt;
      sp_r <= sp_nxt;
      flag_r <= flag_nxt;
      irq_r <= flag_nxt & ien_nxt;
      gval_r <= gval_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tclk_prev_r <= 1'b0;
      t0_prev_r <= TGC_T0_ZERO;
      t0_pulse_r <= 1'b0;
      cmp_s_r <= 1'b0;
    end else begin
      tclk_prev_r <= i_tclk_pin;
      t0_prev_r <= i_t0_count;
      // one-cycle high pulse on the ff to 00 wrap
      // assumes the eight-bit timer steps at most once per clock
      t0_pulse_r <= (t0_prev_r == TGC_T0_TOP) && (i_t0_count == TGC_T0_ZERO);
      if (tclk_tick) begin
        cmp_s_r <= i_cmp_out;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      act_prev_r <= 1'b0;
      tff_r <= 1'b0;
      tg_prev_r <= 1'b0;
    end else begin
      act_prev_r <= act_lvl;
      // the flop is pinned low while toggle mode is off so the measured edge is known
      if (!cfg.tm) begin
        tff_r <= 1'b0;
      end else if (act_rise) begin
        tff_r <= ~tff_r;
      end
      tg_prev_r <= tg;
    end
  end

  // enabling toggle and changing polarity in one write may yield an extra edge
  assign o_gate_value = gval_r;
  assign o_gate_irq = irq_r;
  assign o_count = count_r;

endmodule

// *** tgc_checker.sv ***
// checker: port-level assertions for the timer gate block
`timescale 1ns/1ps
module tgc_checker #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // apb
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // status
  input wire logic o_gate_value,
  input wire logic o_gate_irq,
  input wire logic [CNT_W-1:0] o_count
);
  wire logic acc = i_psel && i_penable;
  wire logic mapped = (i_paddr <= 8'h14) && (i_paddr[1:0] == 2'b00);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("pready held too long");
  a_ready_late: assert property ($rose(acc) |-> !o_pready ##1 o_pready) else $error("pready not after one wait");
  a_err_unmapped: assert property (acc && o_pready && !mapped |-> o_pslverr) else $error("no error on unmapped");
  a_err_mapped: assert property (acc && o_pready && mapped |-> !o_pslverr) else $error("error on mapped");
  a_err_zero_data: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0) else $error("bad error answer");
  a_rdata_upper: assert property (o_pready |-> o_prdata[31:8] == 24'h0) else $error("upper read bits set");
  // a write may load the count, anything else moves it by one at most
  a_count_step: assert property (o_count != $past(o_count) && !$past(o_pready && i_pwrite)
    |-> o_count == $past(o_count) + 1'b1) else $error("count jumped");
  a_irq_sticky: assert property (o_gate_irq && !(i_psel && i_pwrite) |=> o_gate_irq) else $error("irq dropped");
  cover property ($fell(o_gate_value));
  cover property (o_pslverr);
  cover property ($rose(o_gate_irq));
endmodule
bind tgc_top tgc_checker #(.CNT_W(CNT_W)) i_tgc_checker (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_gate_value(o_gate_value), .o_gate_irq(o_gate_irq), .o_count(o_count));

// *** tgc_src_model.sv ***
// partner: gate pin, eight-bit timer, comparator and clock pin sources
`timescale 1ns/1ps
module tgc_src_model (
  // clock
  input wire logic i_clk,
  // commands from the bench
  input wire logic i_gate_lvl,
  input wire logic i_cmp_lvl,
  input wire logic i_t0_run,
  // sources
  output logic o_gate_pin,
  output logic [7:0] o_t0_count,
  output logic o_cmp_out,
  output logic o_tclk_pin
);
  initial begin
    o_gate_pin = 1'b0;
    o_t0_count = 8'h00;
    o_cmp_out = 1'b0;
    o_tclk_pin = 1'b0;
  end
  always @(posedge i_clk) begin
    o_gate_pin <= i_gate_lvl;
    o_cmp_out <= i_cmp_lvl;
    // runs free; only counted when the external clock source is picked
    o_tclk_pin <= ~o_tclk_pin;
    if (i_t0_run) begin
      o_t0_count <= o_t0_count + 8'h01;
    end
  end
endmodule

// *** testbench.sv ***
// testbench: register, gating, source, toggle, single-pulse and event checks
`timescale 1ns/1ps
module testbench;
  import tgc_pkg::*;
  logic i_clk = 0, i_rst_n = 0, psel = 0, pen = 0, pwr = 0, gate_lvl = 0, cmp_lvl = 0, t0_run = 0;
  logic [7:0] paddr = 8'h00, t0, rv;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, gpin, cmp, tclk, gv, irq, ev;
  logic [15:0] cnt, c0;
  int fails = 0, checked = 0, i, s;
  always #5 i_clk = ~i_clk;
  tgc_src_model i_tgc_src_model (.i_clk(i_clk), .i_gate_lvl(gate_lvl), .i_cmp_lvl(cmp_lvl), .i_t0_run(t0_run),
    .o_gate_pin(gpin), .o_t0_count(t0), .o_cmp_out(cmp), .o_tclk_pin(tclk));
  tgc_top i_tgc_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_gate_pin(gpin), .i_t0_count(t0), .i_cmp_out(cmp), .i_tclk_pin(tclk), .o_gate_value(gv),
    .o_gate_irq(irq), .o_count(cnt));
  task automatic stop_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // one idle edge after each transfer keeps psel from being set twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge i_clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rv = prdata[7:0];
    ev = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      stop_test();
    end
    @(posedge i_clk);
  endtask
  task automatic pulse();
    gate_lvl <= 1'b1;
    wt(6);
    gate_lvl <= 1'b0;
    wt(6);
  endtask
  initial begin
    i = $urandom(32'h04f4);
    wt(20);
    i_rst_n <= 1'b1;
    wt(1);
    for (i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 8'h00);
      chk("reset value", {8'h00, rv}, (i == 3) ? 16'h0004 : 16'h0000);
    end
    apb(1'b1, 8'h18, 8'h5a);
    chk("unmapped error", {15'h0, ev}, 16'h0001);
    $display("test registers done");
    apb(1'b1, TGC_OFS_CNT_LOW, 8'h34);
    apb(1'b1, TGC_OFS_CNT_HIGH, 8'h12);
    chk("count", cnt, 16'h1234);
    apb(1'b1, TGC_OFS_TCTRL, 8'h01);
    for (i = 0; i < 6; i++) begin
      s = $urandom;
      gate_lvl <= s[0];
      apb(1'b1, TGC_OFS_GCTRL, {1'b1, s[1], 6'h00});
      wt(4);
      c0 = cnt;
      wt(10);
      chk("gated count", {15'h0, cnt !== c0}, {15'h0, s[0] == s[1]});
    end
    gate_lvl <= 1'b0;
    apb(1'b1, TGC_OFS_GCTRL, 8'h40);
    c0 = cnt;
    wt(10);
    chk("free count", cnt - c0, 16'h000a);
    apb(1'b1, TGC_OFS_TCTRL, 8'h00);
    $display("test gating done");
    for (s = 0; s < 4; s++) begin
      i = $urandom;
      gate_lvl <= i[0];
      cmp_lvl <= i[0];
      apb(1'b1, TGC_OFS_TCTRL, {6'h00, i[1], 1'b0});
      apb(1'b1, TGC_OFS_GCTRL, {2'b01, 4'h0, s[1:0]});
      wt(6);
      apb(1'b0, TGC_OFS_GCTRL, 8'h00);
      chk("gate value", {15'h0, rv[TGC_GC_VAL]}, {15'h0, i[0] & ~s[0]});
    end
    gate_lvl <= 1'b0;
    apb(1'b1, TGC_OFS_GCTRL, 8'h01);
    apb(1'b1, TGC_OFS_FLAG, 8'h00);
    t0_run <= 1'b1;
    wt(300);
    t0_run <= 1'b0;
    apb(1'b1, TGC_OFS_FLAG, 8'h01);
    apb(1'b0, TGC_OFS_FLAG, 8'h00);
    chk("wrap flag", {8'h00, rv}, 16'h0001);
    apb(1'b1, TGC_OFS_FLAG, 8'h00);
    apb(1'b1, TGC_OFS_GCTRL, 8'h00);
    pulse();
    chk("irq masked", {15'h0, irq}, 16'h0000);
    apb(1'b1, TGC_OFS_IEN, 8'h01);
    wt(2);
    chk("irq enabled", {15'h0, irq}, 16'h0001);
    apb(1'b1, TGC_OFS_FLAG, 8'h00);
    chk("irq cleared", {15'h0, irq}, 16'h0000);
    $display("test sources done");
    apb(1'b1, TGC_OFS_TCTRL, 8'h01);
    apb(1'b1, TGC_OFS_GCTRL, 8'hc0);
    apb(1'b1, TGC_OFS_GCTRL, 8'he0);
    pulse();
    chk("toggle one", {15'h0, gv}, 16'h0001);
    pulse();
    chk("toggle two", {15'h0, gv}, 16'h0000);
    pulse();
    apb(1'b1, TGC_OFS_GCTRL, 8'hc0);
    apb(1'b1, TGC_OFS_GCTRL, 8'he0);
    pulse();
    chk("toggle cleared", {15'h0, gv}, 16'h0001);
    apb(1'b1, TGC_OFS_GCTRL, 8'hc0);
    $display("test toggle done");
    apb(1'b1, TGC_OFS_GCTRL, 8'hd0);
    apb(1'b1, TGC_OFS_GCTRL, 8'hd8);
    apb(1'b0, TGC_OFS_GCTRL, 8'h00);
    chk("go set", {15'h0, rv[TGC_GC_GO]}, 16'h0001);
    c0 = cnt;
    gate_lvl <= 1'b1;
    wt(8);
    chk("pulse counts", {15'h0, cnt !== c0}, 16'h0001);
    gate_lvl <= 1'b0;
    wt(6);
    apb(1'b0, TGC_OFS_GCTRL, 8'h00);
    chk("go done", {15'h0, rv[TGC_GC_GO]}, 16'h0000);
    c0 = cnt;
    pulse();
    chk("pulse blocked", cnt, c0);
    apb(1'b1, TGC_OFS_GCTRL, 8'hf0);
    apb(1'b1, TGC_OFS_GCTRL, 8'hf8);
    pulse();
    apb(1'b0, TGC_OFS_GCTRL, 8'h00);
    chk("cycle half", {15'h0, rv[TGC_GC_GO]}, 16'h0001);
    pulse();
    apb(1'b0, TGC_OFS_GCTRL, 8'h00);
    chk("cycle done", {15'h0, rv[TGC_GC_GO]}, 16'h0000);
    apb(1'b1, TGC_OFS_GCTRL, 8'h80);
    $display("test single pulse done");
    apb(1'b1, TGC_OFS_TCTRL, 8'hb1);
    wt(2 + $urandom % 16);
    apb(1'b1, TGC_OFS_CNT_HIGH, 8'h00);
    apb(1'b1, TGC_OFS_CNT_LOW, 8'h00);
    wt(156);
    chk("pin clock count", cnt, 16'h0009);
    $display("test clock source done");
    stop_test();
  end
endmodule
